//--- hdl/ebc_seq.sv
// External bus cycle sequencer: five programmable phases per access
`timescale 1ns/1ns
module ebc_seq #(
   parameter int NREG  = 4,
   parameter int RGN_W = 2
) (
   input  wire logic                      clk_sys,       // System clock
   input  wire logic                      srst,          // Sync reset
   input  wire logic                      reqValid,      // Access request
   output logic                           reqReady,      // Sequencer idle
   input  wire logic                      reqWrite,      // 1 write, 0 read
   input  wire logic [RGN_W-1:0]          reqRegion,     // Chip-select region
   input  wire logic [ebc_pkg::ADDR_W-1:0] reqAddr,      // Byte address
   input  wire logic [ebc_pkg::DATA_W-1:0] reqWdata,     // Write data
   input  wire logic [1:0]                reqByteEn,     // Low/high byte
   output logic                           rspValid,      // Read data pulse
   output logic [ebc_pkg::DATA_W-1:0]     rspRdata,      // Captured read
   input  wire logic [NREG-1:0]           cfgAddrSetup2, // Setup 2 units
   input  wire logic [NREG-1:0][ebc_pkg::UNIT_W-1:0] cfgWinExt, // Extra
   input  wire logic [NREG-1:0][ebc_pkg::UNIT_W-1:0] cfgCmdDly, // C
   input  wire logic [NREG-1:0]           cfgWrSetup,    // D 0 or 1
   input  wire logic [NREG-1:0][ebc_pkg::ACC_W-1:0] cfgAccess, // E-1
   input  wire logic [NREG-1:0][ebc_pkg::UNIT_W-1:0] cfgHold,  // F
   input  wire logic [NREG-1:0]           cfgMux,        // Shared bus
   input  wire logic [NREG-1:0]           cfgRdyEn,      // Ready used
   input  wire logic [NREG-1:0]           cfgRdyPol,     // Ready level
   input  wire logic [NREG-1:0]           cfgRdyAsync,   // Async ready
   input  wire logic                      readyIn,       // Ready pin
   input  wire logic                      clkOutSrcSys,  // Source select
   input  wire logic                      clkOutFastEn,  // Fast driver
   output logic                           busRefClkOut,  // Ref clock
   output logic                           chipSelN,      // Chip select
   output logic                           addrLatchEn,   // Address latch
   output logic                           byteHighEnableN, // High byte
   output logic                           rdN,           // Read strobe
   output logic                           wrLowN,        // Write low
   output logic                           wrHighN,       // Write high
   output logic [ebc_pkg::ADDR_W-1:0]     sepAddrBus,    // Address pins
   output logic [ebc_pkg::DATA_W-1:0]     sharedAdOut,   // Shared out
   output logic                           sharedAdOeN,   // Low: drive
   input  wire logic [ebc_pkg::DATA_W-1:0] sharedAdIn,   // Shared in
   output logic [ebc_pkg::DATA_W-1:0]     sepDataOut,    // Data out
   output logic                           sepDataOeN,    // Low: drive
   input  wire logic [ebc_pkg::DATA_W-1:0] sepDataIn     // Data in
);
   import ebc_pkg::*;

   typedef struct packed {
      ebc_phase_t          ph;
      logic [CNT_W-1:0]    cnt;
      logic [CNT_W-1:0]    abRun;
      logic [RGN_W-1:0]    rgn;
      logic [RGN_W-1:0]    prevRgn;
      logic                seen;
      logic                write;
      logic [1:0]          be;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
      logic [DATA_W-1:0]   rdata;
      logic                rspV;
      logic                rdy1;
      logic                rdy2;
      logic                csN;
      logic                ale;
      logic                hiByteN;
      logic                rdN;
      logic                wrLN;
      logic                wrHN;
      logic [DATA_W-1:0]   adOut;
      logic                adOeN;
      logic [DATA_W-1:0]   dOut;
      logic                dOeN;
   } ebc_state_t;

   localparam ebc_state_t ST_RST = '{
      ph: PH_IDLE, csN: PIN_IDLE, hiByteN: PIN_IDLE, rdN: PIN_IDLE,
      wrLN: PIN_IDLE, wrHN: PIN_IDLE, adOeN: PIN_IDLE,
      dOeN: PIN_IDLE, default: '0};

   ebc_state_t q;
   ebc_state_t d;
   logic       rdyLvl;
   logic       rdyAct;
   logic       accEnd;
   logic       winChg;
   logic       strobe;
   logic [AB_W-1:0] abUnits;

   // Phase that follows, skipping phases programmed to zero units
   function automatic ebc_phase_t nextPh(ebc_phase_t ph,
                                         logic [RGN_W-1:0] r);
      ebc_phase_t n;
      case (ph)
         PH_AB: begin
            if (cfgCmdDly[r] != '0) n = PH_C;
            else if (cfgWrSetup[r]) n = PH_D;
            else n = PH_E;
         end
         PH_C: n = cfgWrSetup[r] ? PH_D : PH_E;
         PH_D: n = PH_E;
         PH_E: n = (cfgHold[r] != '0) ? PH_F : PH_IDLE;
         default: n = PH_IDLE;
      endcase
      return n;
   endfunction

   // Units of a phase minus one, loaded into the down counter
   function automatic logic [CNT_W-1:0] phLoad(ebc_phase_t ph,
                                               logic [RGN_W-1:0] r);
      logic [CNT_W-1:0] n;
      case (ph)
         PH_C: n = CNT_W'(cfgCmdDly[r]) - 6'h01;
         PH_D: n = 6'h00;
         PH_E: n = CNT_W'(cfgAccess[r]);
         PH_F: n = CNT_W'(cfgHold[r]) - 6'h01;
         default: n = 6'h00;
      endcase
      return n;
   endfunction

   // Reference clock is the system clock itself, gated by its selects
   assign busRefClkOut = clk_sys & clkOutSrcSys & clkOutFastEn;

   // Request side handshake and registered pin outputs
   assign reqReady        = (q.ph == PH_IDLE);
   assign rspValid        = q.rspV;
   assign rspRdata        = q.rdata;
   assign chipSelN        = q.csN;
   assign addrLatchEn     = q.ale;
   assign byteHighEnableN = q.hiByteN;
   assign rdN             = q.rdN;
   assign wrLowN          = q.wrLN;
   assign wrHighN         = q.wrHN;
   assign sepAddrBus      = q.addr;
   assign sharedAdOut     = q.adOut;
   assign sharedAdOeN     = q.adOeN;
   assign sepDataOut      = q.dOut;
   assign sepDataOeN      = q.dOeN;

   // Sequencer next state and the pin levels of the phase entered
   always_comb begin
      d = q;
      d.rspV = 1'b0;
      // Run length of the address setup phase, watched by its bound check
      d.abRun = (q.ph == PH_AB) ? q.abRun + 6'h01 : '0;
      // Two-flop stage; the second flop is the only reader of the first
      d.rdy1 = readyIn;
      d.rdy2 = q.rdy1;
      // Async mode costs two extra wait states for metastability safety
      rdyLvl = cfgRdyAsync[q.rgn] ? q.rdy2 : readyIn;
      rdyAct = (rdyLvl == cfgRdyPol[q.rgn]);
      accEnd = (q.cnt == '0) && (!cfgRdyEn[q.rgn] || rdyAct);
      winChg = q.seen && (reqRegion != q.prevRgn);
      abUnits = AB_BASE + AB_W'(cfgAddrSetup2[reqRegion]);
      if (winChg)
         abUnits = abUnits + AB_W'(cfgWinExt[reqRegion]);
      case (q.ph)
         PH_IDLE: begin
            if (reqValid) begin
               d.ph = PH_AB;
               d.cnt = CNT_W'(abUnits) - 6'h01;
               d.rgn = reqRegion;
               d.prevRgn = reqRegion;
               d.seen = 1'b1;
               d.write = reqWrite;
               d.be = reqByteEn;
               d.addr = reqAddr;
               d.wdata = reqWdata;
            end
         end
         PH_E: begin
            if (accEnd) begin
               d.ph = nextPh(q.ph, q.rgn);
               d.cnt = phLoad(d.ph, q.rgn);
               // Sampled on the edge that also raises the read strobe
               if (!q.write) begin
                  d.rspV = 1'b1;
                  d.rdata = cfgMux[q.rgn] ? sharedAdIn : sepDataIn;
               end
            end else if (q.cnt != '0) begin
               d.cnt = q.cnt - 6'h01;
            end
         end
         PH_AB, PH_C, PH_D, PH_F: begin
            if (q.cnt == '0) begin
               d.ph = nextPh(q.ph, q.rgn);
               d.cnt = phLoad(d.ph, q.rgn);
            end else begin
               d.cnt = q.cnt - 6'h01;
            end
         end
         default: d.ph = PH_IDLE;
      endcase

      // Pin levels follow the phase being entered, so they are registered
      strobe = (d.ph == PH_D) || (d.ph == PH_E);
      d.csN = (d.ph == PH_IDLE);
      d.ale = cfgMux[d.rgn] && (d.ph == PH_AB);
      d.hiByteN = d.csN || !d.be[1];
      d.rdN = !(strobe && !d.write);
      d.wrLN = !(strobe && d.write && d.be[0]);
      d.wrHN = !(strobe && d.write && d.be[1]);
      d.adOut = q.adOut;
      d.adOeN = PIN_IDLE;
      d.dOut = q.dOut;
      d.dOeN = PIN_IDLE;
      if (cfgMux[d.rgn]) begin
         // Address first, then bus released or turned to write data
         if (d.ph == PH_AB || d.ph == PH_C) begin
            d.adOut = d.addr[DATA_W-1:0];
            d.adOeN = 1'b0;
         end else if (d.ph != PH_IDLE && d.write) begin
            d.adOut = d.wdata;
            d.adOeN = 1'b0;
         end
      end else if (d.ph >= PH_D && d.ph != PH_IDLE && d.write) begin
         // Write data held through the hold phase
         d.dOut = d.wdata;
         d.dOeN = 1'b0;
      end
   end

   // Single state register
   always_ff @(posedge clk_sys) begin
      if (srst) q <= ST_RST;
      else q <= d;
   end

   chk_cs_phase: assert property (@(posedge clk_sys) disable iff (srst)
      (q.ph != PH_IDLE) == !q.csN)
      else $error("chip select does not match cycle activity");

   chk_ab_bound: assert property (@(posedge clk_sys) disable iff (srst)
      (q.ph == PH_AB) |-> (q.abRun < CNT_W'(AB_MAX_UNITS)))
      else $error("address setup phase longer than five units");

   chk_access_count: assert property (@(posedge clk_sys)
      disable iff (srst)
      (q.ph == PH_E && q.cnt != '0) |=> (q.ph == PH_E))
      else $error("access phase ended before its count");

   chk_ready_wait: assert property (@(posedge clk_sys)
      disable iff (srst)
      (q.ph == PH_E && q.cnt == '0 && cfgRdyEn[q.rgn] && !rdyAct)
      |=> (q.ph == PH_E && !q.csN))
      else $error("access phase left while module not ready");

   chk_read_capture: assert property (@(posedge clk_sys)
      disable iff (srst)
      (q.ph == PH_E && d.ph != PH_E && !q.write && !q.rdN)
      |=> (q.rspV && q.rdN))
      else $error("read data not captured with strobe rise");

   chk_strobe_window: assert property (@(posedge clk_sys)
      disable iff (srst)
      (!q.rdN || !q.wrLN || !q.wrHN) |-> (q.ph inside {PH_D, PH_E}))
      else $error("strobe active outside command window");

   chk_ale_addr: assert property (@(posedge clk_sys)
      disable iff (srst)
      q.ale |-> (q.ph == PH_AB && !q.adOeN
                 && q.adOut == q.addr[DATA_W-1:0]))
      else $error("latch enable without address on shared bus");

   chk_mux_turn: assert property (@(posedge clk_sys)
      disable iff (srst)
      (cfgMux[q.rgn] && !q.write && q.ph inside {PH_D, PH_E})
      |-> q.adOeN)
      else $error("shared bus driven during read turnaround");

   chk_demux_wdata: assert property (@(posedge clk_sys)
      disable iff (srst)
      (!cfgMux[q.rgn] && q.write && q.ph == PH_E)
      |-> (!q.dOeN && q.dOut == q.wdata && q.adOeN))
      else $error("demultiplexed write data not on data bus");

   chk_setup_unit: assert property (@(posedge clk_sys)
      disable iff (srst)
      (q.ph == PH_D) |=> (q.ph != PH_D))
      else $error("write setup phase longer than one unit");

   chk_hibyte_cycle: assert property (@(posedge clk_sys)
      disable iff (srst)
      !q.hiByteN |-> (!q.csN && q.be[1]))
      else $error("byte-high enable outside a high-byte cycle");

   chk_rsp_pulse: assert property (@(posedge clk_sys)
      disable iff (srst)
      q.rspV |=> !q.rspV)
      else $error("read data valid longer than one cycle");
endmodule

//--- hdl/ebc_pkg.sv
// Shared widths, phase encoding and timing constants of the bus sequencer
package ebc_pkg;
   // Bus geometry
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   // Field widths of the per-region timing configuration, the address setup sum and the phase counter
   localparam int UNIT_W = 2;
   localparam int ACC_W  = 5;
   localparam int AB_W   = 3;
   localparam int CNT_W  = 6;
   // One phase unit is one system clock period
   localparam int SYS_CLK_NS = 20;
   localparam int UNIT_NS    = 20;
   localparam int UNIT_CYC   = (UNIT_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   // Longest address setup phase, window change included
   localparam logic [AB_W-1:0] AB_MAX_UNITS = 3'h5;
   localparam logic [AB_W-1:0] AB_BASE      = 3'h1;
   // Idle level of the active-low strobes and enables
   localparam logic PIN_IDLE = 1'b1;

   // Phases of one external bus cycle
   typedef enum logic [2:0] {
      PH_IDLE,
      PH_AB,
      PH_C,
      PH_D,
      PH_E,
      PH_F
   } ebc_phase_t;
endpackage

//--- verif/ebc_ext_mem.sv
// Behavioural external memory with ready handshake on the bus pins
`timescale 1ns/1ns
module ebc_ext_mem (
   input  wire logic        clk_sys,     // System clock
   input  wire logic        chipSelN,    // Chip select
   input  wire logic        addrLatchEn, // Address latch
   input  wire logic        rdN,         // Read strobe
   input  wire logic        wrLowN,      // Write low byte
   input  wire logic        wrHighN,     // Write high byte
   input  wire logic [23:0] sepAddrBus,  // Address pins
   input  wire logic [15:0] sharedAdOut, // Shared bus level
   input  wire logic [15:0] sepDataOut,  // Data bus level
   input  wire logic        muxMode,     // Shared bus mode
   input  wire logic        rdyPol,      // Ready level
   input  wire logic [3:0]  rdyWait,     // Strobe cycles before ready
   output logic             readyIn,     // Ready pin
   output logic [15:0]      sharedAdIn,  // Shared bus read data
   output logic [15:0]      sepDataIn    // Data bus read data
);
   logic [15:0] mem [16];
   logic [3:0]  latQ = 4'h0;
   logic [15:0] lastQ = 16'h0;
   logic [3:0]  cntQ = 4'h0;
   wire  [3:0]  wa = muxMode ? latQ : sepAddrBus[3:0];
   wire         drv = !chipSelN && !rdN;
   wire  [15:0] wd = muxMode ? sharedAdOut : sepDataOut;
   // Released data shows the inverse so stale values cannot pass
   assign sepDataIn  = (drv && !muxMode) ? mem[wa] : ~lastQ;
   assign sharedAdIn = (drv && muxMode) ? mem[wa] : ~lastQ;
   // Ready is released with the strobe so it never leaks into the next cycle
   wire         strb = !rdN || !wrLowN || !wrHighN;
   assign readyIn = rdyPol ~^ (strb && cntQ >= rdyWait);
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 16'h0;
   end
   // Latch address, store bytes, count strobe cycles for ready
   always @(posedge clk_sys) begin
      if (addrLatchEn) latQ <= sharedAdOut[3:0];
      if (drv) lastQ <= mem[wa];
      if (!chipSelN && !wrLowN) mem[wa][7:0] <= wd[7:0];
      if (!chipSelN && !wrHighN) mem[wa][15:8] <= wd[15:8];
      cntQ <= (rdN && wrLowN && wrHighN) ? 4'h0 : cntQ + (cntQ != 4'hf);
   end
endmodule

//--- verif/test_ebc_seq.sv
// Self-checking bench for the external bus cycle sequencer
`timescale 1ns/1ns
module test_ebc_seq;
   typedef struct packed {
      logic mux, wr;
      logic [1:0] rgn;
      logic [23:0] addr;
      logic [15:0] dat;
      logic [1:0] be;
      logic s2;
      logic [1:0] wx, cmd;
      logic wrs;
      logic [4:0] acc;
      logic [1:0] hold;
   } ebc_row_t;
   logic clk_sys = 0, srst = 1, reqValid = 0, reqWrite = 0, first = 1;
   logic clkOutSrcSys = 1, clkOutFastEn = 1;
   logic [1:0] reqRegion = 0, reqByteEn = 0, prevRgn = 0;
   logic [23:0] reqAddr = 0, sepAddrBus;
   logic [15:0] reqWdata = 0, rspRdata, sharedAdOut, sepDataOut, memAd, memSep;
   logic [3:0] cfgAddrSetup2 = 0, cfgWrSetup = 0, cfgMux = 0, cfgRdyEn = 0;
   logic [3:0] cfgRdyPol = 4'hf, cfgRdyAsync = 0, rdyWait = 0;
   logic [3:0][1:0] cfgWinExt = 0, cfgCmdDly = 0, cfgHold = 0;
   logic [3:0][4:0] cfgAccess = 0;
   logic reqReady, rspValid, busRefClkOut, chipSelN, addrLatchEn, readyIn;
   logic byteHighEnableN, rdN, wrLowN, wrHighN, sharedAdOeN, sepDataOeN;
   int fails = 0, cmpCount = 0, s1, s2, s3;
   ebc_row_t rows [8] = '{
      '{0,1,0,24'h2,16'ha5c3,3,0,0,0,0,0,0},
      '{0,0,0,24'h2,16'ha5c3,3,1,0,3,1,31,3},
      '{1,1,1,24'h5,16'h1234,1,1,3,0,0,0,0},
      '{1,0,1,24'h5,16'h0034,3,0,0,0,1,1,0},
      '{1,1,1,24'h5,16'hab00,2,0,0,1,0,2,1},
      '{0,0,2,24'h5,16'hab34,3,0,1,0,0,0,2},
      '{1,1,3,24'h9,16'h5a5a,3,0,2,2,0,4,0},
      '{0,0,3,24'h9,16'h5a5a,3,0,0,0,0,0,0}};
   // Wire level is the driving party's value
   wire [15:0] sharedAdIn = sharedAdOeN ? memAd : sharedAdOut;
   wire [15:0] sepDataIn  = sepDataOeN ? memSep : sepDataOut;
   ebc_seq DUT (.clk_sys, .srst, .reqValid, .reqReady, .reqWrite, .reqRegion,
      .reqAddr, .reqWdata, .reqByteEn, .rspValid, .rspRdata, .cfgAddrSetup2,
      .cfgWinExt, .cfgCmdDly, .cfgWrSetup, .cfgAccess, .cfgHold, .cfgMux,
      .cfgRdyEn, .cfgRdyPol, .cfgRdyAsync, .readyIn, .clkOutSrcSys,
      .clkOutFastEn, .busRefClkOut, .chipSelN, .addrLatchEn, .byteHighEnableN,
      .rdN, .wrLowN, .wrHighN, .sepAddrBus, .sharedAdOut, .sharedAdOeN,
      .sharedAdIn, .sepDataOut, .sepDataOeN, .sepDataIn);
   ebc_ext_mem MEM (.clk_sys, .chipSelN, .addrLatchEn, .rdN, .wrLowN,
      .wrHighN, .sepAddrBus, .sharedAdOut, .sepDataOut, .muxMode(cfgMux[0]),
      .rdyPol(cfgRdyPol[0]), .rdyWait, .readyIn, .sharedAdIn(memAd),
      .sepDataIn(memSep));
   // 50 MHz system clock
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", cmpCount, fails);
      if (fails == 0 && cmpCount > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Reset, then every strobe and enable must be idle
   task automatic do_reset;
      srst = 1;
      repeat (8) @(negedge clk_sys);
      srst = 0;
      first = 1;
      check({chipSelN, rdN, wrLowN, wrHighN, byteHighEnableN, sharedAdOeN,
         sepDataOeN, addrLatchEn, reqReady, rspValid}, 24'h3fa);
      $display("Reset test done");
   endtask
   // One access; counts pin cycles and compares with programmed phases
   task automatic run(input ebc_row_t r, input logic en, output int st);
      int cs, wl, wh, bh, ab, rc, i;
      logic got;
      logic [15:0] rd;
      cs = 0; wl = 0; wh = 0; bh = 0; rc = 0; got = 0; rd = 0;
      ab = 1 + r.s2 + ((!first && r.rgn != prevRgn) ? r.wx : 0);
      first = 0;
      prevRgn = r.rgn;
      {reqWrite, reqRegion, reqAddr, reqWdata, reqByteEn} =
         {r.wr, r.rgn, r.addr, r.dat, r.be};
      cfgAddrSetup2 = {4{r.s2}}; cfgWinExt = {4{r.wx}}; cfgCmdDly = {4{r.cmd}};
      cfgWrSetup = {4{r.wrs}}; cfgAccess = {4{r.acc}}; cfgHold = {4{r.hold}};
      cfgMux = {4{r.mux}};
      cfgRdyEn = {4{en}};
      reqValid = 1;
      @(negedge clk_sys);
      reqValid = 0;
      check(reqReady, 0);
      for (i = 0; i < 200 && reqReady !== 1; i++) begin
         cs += (chipSelN === 0);
         rc += (rdN === 0);
         bh += (byteHighEnableN === 0);
         wl += (wrLowN === 0);
         wh += (wrHighN === 0);
         if (rspValid === 1) {got, rd} = {1'b1, rspRdata};
         if (addrLatchEn === 1) check(sharedAdOut, r.addr[15:0]);
         if (rdN === 0 && !r.mux) check(sepAddrBus, r.addr);
         if (rdN === 0) check({sharedAdOeN, sepDataOeN}, 2'b11);
         if ((wrLowN & wrHighN) === 0) begin
            check({sharedAdOeN, sepDataOeN}, {!r.mux, r.mux});
            check(r.mux ? sharedAdOut : sepDataOut, r.dat);
         end
         @(negedge clk_sys);
      end
      // A read with no hold phase pulses its valid in the first idle cycle
      if (rspValid === 1) {got, rd} = {1'b1, rspRdata};
      if (i == 200) begin
         fails++;
         end_of_test;
      end
      st = rc + (wl > wh ? wl : wh);
      check(cs - st, ab + r.cmd + r.hold);
      if (!en) check(st, r.wrs + r.acc + 1);
      check(wl, (r.wr && r.be[0]) ? st : 0);
      check(wh, (r.wr && r.be[1]) ? st : 0);
      check(bh != 0, r.be[1]);
      if (!r.wr) check({got, rd}, {1'b1, r.dat});
      $display("Access test done at %h", r.addr);
   endtask
   initial begin
      do_reset;
      for (int k = 0; k < 8; k++) run(rows[k], 0, s1);
      rdyWait = 4'h3;
      run(rows[7], 1, s1);
      check(s1, rdyWait + 1);
      cfgRdyAsync = 4'hf;
      run(rows[7], 1, s2);
      check(s2 > s1, 1);
      cfgRdyAsync = 0;
      cfgRdyPol = 0;
      run(rows[7], 1, s3);
      check(s3 == s1, 1);
      $display("Ready tests done");
      @(posedge clk_sys);
      #5 check(busRefClkOut, 1);
      @(negedge clk_sys);
      #5 check(busRefClkOut, 0);
      @(negedge clk_sys);
      clkOutFastEn = 0;
      @(posedge clk_sys);
      #5 check(busRefClkOut, 0);
      @(negedge clk_sys);
      clkOutFastEn = 1;
      clkOutSrcSys = 0;
      @(posedge clk_sys);
      #5 check(busRefClkOut, 0);
      @(negedge clk_sys);
      $display("Clock output test done");
      reqValid = 1;
      @(negedge clk_sys);
      reqValid = 0;
      @(negedge clk_sys);
      do_reset;
      run(rows[0], 0, s1);
      end_of_test;
   end
endmodule
